// >>> src/gpx_map.svh
// Register offsets, field positions, reset values and bus addresses of the expander.
`ifndef GPX_MAP_SVH
`define GPX_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (command byte values)
// ----------------------------------------------------------------
`define GPX_OFF_CTRL 8'h01
`define GPX_OFF_DIR 8'h03
`define GPX_OFF_OUT 8'h05
`define GPX_OFF_HIZ 8'h07
`define GPX_OFF_DFLT 8'h09
`define GPX_OFF_PULL_EN 8'h0B
`define GPX_OFF_PULL_SEL 8'h0D
`define GPX_OFF_LEVEL 8'h0F
`define GPX_OFF_MASK 8'h11
`define GPX_OFF_PEND 8'h13

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define GPX_CTRL_SWRST 0
`define GPX_CTRL_RSTFLAG 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GPX_RST_DIR 8'h00
`define GPX_RST_OUT 8'h00
`define GPX_RST_HIZ 8'hFF
`define GPX_RST_DFLT 8'h00
`define GPX_RST_PULL_EN 8'hFF
`define GPX_RST_PULL_SEL 8'h00
`define GPX_RST_MASK 8'h00
`define GPX_RST_PEND 8'h00
`define GPX_RST_PTR 8'h00

// ----------------------------------------------------------------
// Seven-bit target addresses selected by the address strap
// ----------------------------------------------------------------
`define GPX_I2C_ADDR0 7'h43
`define GPX_I2C_ADDR1 7'h44

`endif

// >>> src/gpx_pkg.sv
// Types shared by the expander core and its serial target.
package gpx_pkg;
   typedef enum logic [2:0] {GPX_IDLE, GPX_RX, GPX_ACK, GPX_TX, GPX_MACK} gpx_i2c_state_t;
   typedef enum logic [1:0] {GPX_PH_ADDR, GPX_PH_CMD, GPX_PH_DATA} gpx_phase_t;
endpackage

// >>> src/gpx_i2c_target.sv
// Two-wire serial target: address match, command pointer, single-register read and write.
`timescale 1ns/10ps
`include "gpx_map.svh"

module gpx_i2c_target import gpx_pkg::*; (
   input wire logic clk, // System clock.
   input wire logic rst_n, // Synchronous active-low reset of the target.
   input wire logic addr_sel, // Synchronised address strap.
   input wire logic scl_i, // Serial clock pin level.
   input wire logic sda_i, // Serial data pin level.
   output logic sda_oe_n, // Low while the data line is pulled low.
   output logic wr_stb, // One-cycle pulse: wr_data goes to register ptr.
   output logic rd_stb, // One-cycle pulse: rd_data of register ptr was taken.
   output logic [7:0] ptr, // Register pointer loaded by the command byte.
   output logic [7:0] wr_data, // Data byte of a write.
   input wire logic [7:0] rd_data // Contents of the register at ptr.
);

   // ----------------------------------------------------------------
   // Line synchronisers and condition detection
   // ----------------------------------------------------------------
   logic [2:0] scl_sy;
   logic [2:0] sda_sy;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic [6:0] dev_addr;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scl_sy <= 3'h7;
         sda_sy <= 3'h7;
      end else begin
         scl_sy <= {scl_sy[1:0], scl_i};
         sda_sy <= {sda_sy[1:0], sda_i};
      end
   end

   assign scl_rise = scl_sy[1] & ~scl_sy[2];
   assign scl_fall = ~scl_sy[1] & scl_sy[2];
   assign start_cond = scl_sy[1] & scl_sy[2] & ~sda_sy[1] & sda_sy[2];
   assign stop_cond = scl_sy[1] & scl_sy[2] & sda_sy[1] & ~sda_sy[2];
   assign dev_addr = addr_sel ? `GPX_I2C_ADDR1 : `GPX_I2C_ADDR0;

   // ----------------------------------------------------------------
   // Byte engine
   // ----------------------------------------------------------------
   gpx_i2c_state_t state_r;
   gpx_phase_t phase_r;
   logic [3:0] cnt_r;
   logic [7:0] shreg_r;
   logic rw_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= GPX_IDLE;
         phase_r <= GPX_PH_ADDR;
         cnt_r <= 4'h0;
         shreg_r <= 8'h00;
         rw_r <= 1'b0;
         ptr <= `GPX_RST_PTR;
         wr_data <= 8'h00;
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         if (start_cond) begin
            state_r <= GPX_RX;
            phase_r <= GPX_PH_ADDR;
            cnt_r <= 4'h0;
            sda_oe_n <= 1'b1;
         end else if (stop_cond) begin
            state_r <= GPX_IDLE;
            sda_oe_n <= 1'b1;
         end else begin
            case (state_r)
               GPX_RX: begin
                  if (scl_rise && cnt_r != 4'h8) begin
                     shreg_r <= {shreg_r[6:0], sda_sy[1]};
                     cnt_r <= cnt_r + 4'h1;
                  end else if (scl_fall && cnt_r == 4'h8) begin
                     state_r <= GPX_ACK;
                     sda_oe_n <= 1'b0;
                     case (phase_r)
                        GPX_PH_ADDR: begin
                           rw_r <= shreg_r[0];
                           if (shreg_r[7:1] != dev_addr) begin
                              state_r <= GPX_IDLE;
                              sda_oe_n <= 1'b1;
                           end
                        end
                        GPX_PH_CMD: ptr <= shreg_r; // [RULE_22]
                        default: begin
                           wr_data <= shreg_r;
                           wr_stb <= 1'b1;
                        end
                     endcase
                  end
               end
               GPX_ACK: begin
                  if (scl_fall) begin
                     cnt_r <= 4'h0;
                     if (phase_r == GPX_PH_ADDR && rw_r) begin
                        // Reads use the stored pointer and never advance it.
                        shreg_r <= rd_data; // [RULE_19] [RULE_20]
                        rd_stb <= 1'b1;
                        sda_oe_n <= rd_data[7];
                        state_r <= GPX_TX;
                     end else begin
                        sda_oe_n <= 1'b1;
                        state_r <= GPX_RX;
                        phase_r <= (phase_r == GPX_PH_ADDR) ? GPX_PH_CMD : GPX_PH_DATA;
                     end
                  end
               end
               GPX_TX: begin
                  if (scl_fall) begin
                     if (cnt_r == 4'h7) begin
                        sda_oe_n <= 1'b1;
                        state_r <= GPX_MACK;
                     end else begin
                        cnt_r <= cnt_r + 4'h1;
                        sda_oe_n <= shreg_r[6];
                        shreg_r <= {shreg_r[6:0], 1'b0};
                     end
                  end
               end
               GPX_MACK: begin
                  if (scl_rise) begin
                     state_r <= sda_sy[1] ? GPX_IDLE : GPX_ACK;
                  end
               end
               default: state_r <= GPX_IDLE;
            endcase
         end
      end
   end

endmodule // gpx_i2c_target

// >>> src/gpx_core.sv
// Eight-pin expander core: port control, pulls, readback, change interrupt and resets.
//
// What this block does
// RULE_01: Pull enable 0 disconnects the pin's pull; 1 connects the selected one.
// RULE_02: Pull select 0 picks pull-down, 1 pull-up; select alone connects nothing.
// RULE_03: Level readback shows live input levels, zero for output pins.
// RULE_04: Writes to the level readback register are accepted and change nothing.
// RULE_05: Mask 0 lets a pending bit pull the interrupt; mask 1 blocks, still latches.
// RULE_06: Output pins never set a pending bit nor affect the interrupt output.
// RULE_07: An input differing from its default level sets its pending bit.
// RULE_08: Reading the pending register clears it and releases the interrupt.
// RULE_09: A cleared bit re-arms only after its input returns to default.
// RULE_10: The interrupt stays low as a level until the pending register is read.
// RULE_11: Change detection runs on the system clock, independent of bus clock activity.
// RULE_12: Input pins have both drivers off; outputs with their high-impedance bit clear drive one side from the output bit.
// RULE_13: Output pins have their input buffer disabled.
// RULE_14: Power-on connects pull-downs; afterwards the pull registers steer the switches.
// RULE_15: Power-on reset holds everything until the supply is good, then loads defaults.
// RULE_16: A low reset pin forces all registers to defaults; host holds it long enough.
// RULE_17: Bus access works only while the reset pin is high.
// RULE_18: Writing 1 to control bit 0 resets all registers except the register pointer; the bit reads 0.
// RULE_19: No auto-increment; each read returns one register.
// RULE_20: A read without a command returns the register at the current pointer.
// RULE_21: The interrupt is open-drain, active low, only pulled low or released.
// RULE_22: The command byte after the address loads the register pointer.
// RULE_23: Default-state bits give the reference level for each input pin.
// RULE_24: Direction 1 is output, 0 input; all pins are inputs after reset.
// RULE_25: The reset flag is set by every reset and cleared when the control register is read.
// RULE_26: The interrupt is low while any unmasked input pin has its pending bit set.
`timescale 1ns/10ps
`include "gpx_map.svh"

module gpx_core import gpx_pkg::*; #(
   parameter logic [2:0] MAKER_ID = 3'h2, // Arbitrary value.
   parameter logic [2:0] FW_REV = 3'h1 // Arbitrary value.
) (
   input wire logic clk, // System clock, 20 MHz.
   input wire logic nrst, // Synchronous active-low system reset.
   input wire logic rst_pin_n, // Active-low reset pin.
   input wire logic por_ok, // High once the bus-side supply passed its threshold.
   input wire logic addr_pin, // Target address strap.
   input wire logic scl_i, // Serial clock pin.
   input wire logic sda_i, // Serial data pin level.
   output logic sda_o, // Serial data drive level, always low.
   output logic sda_oe_n, // Low while the data line is pulled low.
   input wire logic [7:0] port_pins, // Port pin levels.
   output logic [7:0] high_side_driver, // Per-pin high-side driver on.
   output logic [7:0] low_side_driver, // Per-pin low-side driver on.
   output logic [7:0] pullup_switch, // Per-pin pull-up connected.
   output logic [7:0] pulldown_switch, // Per-pin pull-down connected.
   output logic [7:0] input_buf_en, // Per-pin input buffer enabled.
   output logic irq_o, // Interrupt drive level, always low.
   output logic irq_oe_n // Low while the interrupt line is pulled low.
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] rst_pin_sy;
   logic [1:0] por_sy;
   logic [1:0] addr_sy;
   logic [7:0] port_sy0;
   logic [7:0] port_sy1;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rst_pin_sy <= 2'h0;
         por_sy <= 2'h0;
         addr_sy <= 2'h0;
         port_sy0 <= 8'h00;
         port_sy1 <= 8'h00;
      end else begin
         rst_pin_sy <= {rst_pin_sy[0], rst_pin_n};
         por_sy <= {por_sy[0], por_ok};
         addr_sy <= {addr_sy[0], addr_pin};
         port_sy0 <= port_pins;
         port_sy1 <= port_sy0;
      end
   end

   // ----------------------------------------------------------------
   // Reset combination
   // ----------------------------------------------------------------
   logic swrst_r;
   logic bus_rst_n;
   logic regs_rst_n;

   // The target only runs while both the pin and the supply are out of reset.
   assign bus_rst_n = nrst & rst_pin_sy[1] & por_sy[1]; // [RULE_15] [RULE_16] [RULE_17]
   assign regs_rst_n = bus_rst_n & ~swrst_r; // [RULE_18]

   // ----------------------------------------------------------------
   // Serial target
   // ----------------------------------------------------------------
   logic wr_stb;
   logic rd_stb;
   logic [7:0] ptr;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   logic sda_oe_n_w;

   gpx_i2c_target u_target (
      .clk(clk),
      .rst_n(bus_rst_n),
      .addr_sel(addr_sy[1]),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_oe_n(sda_oe_n_w),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .ptr(ptr),
      .wr_data(wr_data),
      .rd_data(rd_data)
   );

   assign sda_oe_n = sda_oe_n_w;

   function automatic logic hit(input logic stb, input logic [7:0] p, input logic [7:0] off);
      hit = stb && (p == off);
   endfunction

   // ----------------------------------------------------------------
   // Software reset pulse
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!bus_rst_n) begin
         swrst_r <= 1'b0;
      end else begin
         swrst_r <= hit(wr_stb, ptr, `GPX_OFF_CTRL) & wr_data[`GPX_CTRL_SWRST]; // [RULE_18]
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   logic [7:0] dir_r;
   logic [7:0] out_r;
   logic [7:0] hiz_r;
   logic [7:0] dflt_r;
   logic [7:0] pull_resistor_enable_r;
   logic [7:0] pull_direction_select_r;
   logic [7:0] change_irq_mask_r;

   // The level and pending registers have no write path, so writes to them are no-ops.
   always_ff @(posedge clk) begin
      if (!regs_rst_n) begin
         dir_r <= `GPX_RST_DIR; // [RULE_24]
         out_r <= `GPX_RST_OUT;
         hiz_r <= `GPX_RST_HIZ;
         dflt_r <= `GPX_RST_DFLT;
         pull_resistor_enable_r <= `GPX_RST_PULL_EN; // [RULE_14]
         pull_direction_select_r <= `GPX_RST_PULL_SEL; // [RULE_14]
         change_irq_mask_r <= `GPX_RST_MASK;
      end else if (wr_stb) begin
         case (ptr)
            `GPX_OFF_DIR: dir_r <= wr_data; // [RULE_24]
            `GPX_OFF_OUT: out_r <= wr_data;
            `GPX_OFF_HIZ: hiz_r <= wr_data;
            `GPX_OFF_DFLT: dflt_r <= wr_data; // [RULE_23]
            `GPX_OFF_PULL_EN: pull_resistor_enable_r <= wr_data;
            `GPX_OFF_PULL_SEL: pull_direction_select_r <= wr_data;
            `GPX_OFF_MASK: change_irq_mask_r <= wr_data;
            default: dir_r <= dir_r; // [RULE_04]
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Reset-occurred flag
   // ----------------------------------------------------------------
   logic rst_flag_r;

   always_ff @(posedge clk) begin
      if (!regs_rst_n) begin
         rst_flag_r <= 1'b1; // [RULE_25]
      end else if (hit(rd_stb, ptr, `GPX_OFF_CTRL)) begin
         rst_flag_r <= 1'b0; // [RULE_25]
      end
   end

   // ----------------------------------------------------------------
   // Change detection
   // ----------------------------------------------------------------
   logic [7:0] live_level;
   logic [7:0] off_default;
   logic [7:0] pend_set;
   logic [7:0] pend_clr;
   logic [7:0] change_irq_pending_r;
   logic [7:0] arm_r;

   // Output pins see a disabled input buffer, so they read as zero.
   assign live_level = port_sy1 & ~dir_r; // [RULE_03] [RULE_13]
   assign off_default = (port_sy1 ^ dflt_r) & ~dir_r; // [RULE_06] [RULE_07] [RULE_23]
   assign pend_set = off_default & arm_r; // [RULE_11]
   assign pend_clr = hit(rd_stb, ptr, `GPX_OFF_PEND) ? 8'hFF : 8'h00; // [RULE_08]

   always_ff @(posedge clk) begin
      if (!regs_rst_n) begin
         change_irq_pending_r <= `GPX_RST_PEND;
      end else begin
         // A change caught in the clearing cycle survives the clear.
         change_irq_pending_r <= (change_irq_pending_r & ~pend_clr) | pend_set; // [RULE_07] [RULE_08]
      end
   end

   // A pin arms at its default level and disarms when it fires.
   always_ff @(posedge clk) begin
      if (!regs_rst_n) begin
         arm_r <= 8'h00;
      end else begin
         arm_r <= (arm_r & ~pend_set) | (~off_default & ~dir_r); // [RULE_09]
      end
   end

   // ----------------------------------------------------------------
   // Interrupt output
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!regs_rst_n) begin
         irq_oe_n <= 1'b1;
      end else begin
         // Held low until a pending read clears the causing bits.
         irq_oe_n <= ~|(change_irq_pending_r & ~change_irq_mask_r & ~dir_r); // [RULE_05] [RULE_06] [RULE_10] [RULE_26]
      end
   end

   // The drive level is constant; only the enable moves the line.
   always_ff @(posedge clk) begin
      irq_o <= 1'b0; // [RULE_21]
      sda_o <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Port drivers, pulls and input buffers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!regs_rst_n) begin
         high_side_driver <= 8'h00;
         low_side_driver <= 8'h00;
         input_buf_en <= 8'hFF;
      end else begin
         high_side_driver <= dir_r & ~hiz_r & out_r; // [RULE_12]
         low_side_driver <= dir_r & ~hiz_r & ~out_r; // [RULE_12]
         input_buf_en <= ~dir_r; // [RULE_13]
      end
   end

   always_ff @(posedge clk) begin
      if (!regs_rst_n) begin
         pullup_switch <= 8'h00;
         pulldown_switch <= 8'hFF; // [RULE_14]
      end else begin
         pullup_switch <= pull_resistor_enable_r & pull_direction_select_r; // [RULE_01] [RULE_02]
         pulldown_switch <= pull_resistor_enable_r & ~pull_direction_select_r; // [RULE_01] [RULE_02]
      end
   end

   // ----------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------
   always_comb begin
      case (ptr)
         `GPX_OFF_CTRL: rd_data = {MAKER_ID, FW_REV, rst_flag_r, 1'b0}; // [RULE_18]
         `GPX_OFF_DIR: rd_data = dir_r;
         `GPX_OFF_OUT: rd_data = out_r;
         `GPX_OFF_HIZ: rd_data = hiz_r;
         `GPX_OFF_DFLT: rd_data = dflt_r;
         `GPX_OFF_PULL_EN: rd_data = pull_resistor_enable_r;
         `GPX_OFF_PULL_SEL: rd_data = pull_direction_select_r;
         `GPX_OFF_LEVEL: rd_data = live_level; // [RULE_03]
         `GPX_OFF_MASK: rd_data = change_irq_mask_r;
         `GPX_OFF_PEND: rd_data = change_irq_pending_r;
         default: rd_data = 8'h00;
      endcase
   end

endmodule // gpx_core

// >>> sim/gpx_core_monitor.sv
// Concurrent checks on the pins of the expander core.
`timescale 1ns/10ps

module gpx_core_chk (
   input wire logic clk, // Clock.
   input wire logic nrst, // Reset.
   input wire logic rst_pin_n, // Reset pin.
   input wire logic por_ok, // Supply good.
   input wire logic scl_i, // Serial clock.
   input wire logic sda_o, // Data level.
   input wire logic sda_oe_n, // Data pull.
   input wire logic [7:0] port_pins, // Pins.
   input wire logic [7:0] high_side_driver, // High drivers.
   input wire logic [7:0] low_side_driver, // Low drivers.
   input wire logic [7:0] pullup_switch, // Pull-ups.
   input wire logic [7:0] pulldown_switch, // Pull-downs.
   input wire logic [7:0] input_buf_en, // Input buffers.
   input wire logic irq_o, // Interrupt level.
   input wire logic irq_oe_n // Interrupt pull.
);
   logic [7:0] pins_r;
   logic scl_r;
   logic [4:0] pin_age_r;
   logic [4:0] scl_age_r;

   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   // Ages count cycles since the pins or the serial clock last moved.
   always_ff @(posedge clk) begin
      pins_r <= port_pins;
      scl_r <= scl_i;
      pin_age_r <= (!nrst || port_pins != pins_r) ? 5'h00 : pin_age_r + {4'h0, pin_age_r != 5'h1F};
      scl_age_r <= (!nrst || scl_i != scl_r) ? 5'h00 : scl_age_r + {4'h0, scl_age_r != 5'h1F};
   end

   a_drv_excl: assert property ((high_side_driver & low_side_driver) == 8'h00)
      else $error("both drivers on");
   a_input_float: assert property (
      ((high_side_driver | low_side_driver) & input_buf_en) == 8'h00)
      else $error("input pin driven");
   a_pull_excl: assert property ((pullup_switch & pulldown_switch) == 8'h00)
      else $error("both pulls on");
   a_pin_reset: assert property (!rst_pin_n [*6] |-> pulldown_switch == 8'hFF &&
      pullup_switch == 8'h00 && (high_side_driver | low_side_driver) == 8'h00 && irq_oe_n)
      else $error("pin reset not applied");
   a_por_hold: assert property (!por_ok [*6] |-> pulldown_switch == 8'hFF && irq_oe_n)
      else $error("power-on reset not applied");
   a_bus_quiet: assert property (!rst_pin_n [*4] |-> sda_oe_n)
      else $error("bus answered in reset");
   a_fixed_low: assert property (sda_o == 1'b0 && irq_o == 1'b0)
      else $error("open-drain level high");
   a_irq_cause: assert property ($fell(irq_oe_n) |-> pin_age_r <= 5'h06)
      else $error("interrupt without prompt pin change");
   a_irq_hold: assert property ($rose(irq_oe_n) |-> scl_age_r <= 5'h14 || !rst_pin_n)
      else $error("interrupt released without bus read");

   c_irq: cover property ($fell(irq_oe_n));
   c_ack: cover property ($fell(sda_oe_n));
   c_drive: cover property (high_side_driver != 8'h00);
endmodule // gpx_core_chk

bind gpx_core gpx_core_chk chk (.clk(clk), .nrst(nrst), .rst_pin_n(rst_pin_n), .por_ok(por_ok),
   .scl_i(scl_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .port_pins(port_pins),
   .high_side_driver(high_side_driver), .low_side_driver(low_side_driver),
   .pullup_switch(pullup_switch), .pulldown_switch(pulldown_switch),
   .input_buf_en(input_buf_en), .irq_o(irq_o), .irq_oe_n(irq_oe_n));

// >>> sim/gpx_i2c_master.sv
// Two-wire bus master model that reaches the expander registers.
`timescale 1ns/10ps
`include "gpx_map.svh"

module gpx_i2c_master (
   input wire logic clk, // Lines change at its falling edge.
   output logic scl, // Serial clock, high between frames.
   output logic sda_m, // Data drive, 1 releases the line.
   input wire logic sda // Wired data level.
);
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // One 400 ns bit: data set early in the low phase, sampled late in the high phase.
   task automatic bitx(input logic b, output logic r);
      cyc(1);
      sda_m = b;
      cyc(4);
      scl = 1'b1;
      cyc(2);
      r = sda;
      cyc(1);
      scl = 1'b0;
   endtask

   task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], r[i]);
      end
      bitx(ai, a);
   endtask

   task automatic start(input logic rw, output logic a);
      logic [7:0] r;
      sda_m = 1'b0;
      cyc(4);
      scl = 1'b0;
      xfer({`GPX_I2C_ADDR0, rw}, 1'b1, r, a);
   endtask

   task automatic stop();
      cyc(1);
      sda_m = 1'b0;
      cyc(4);
      scl = 1'b1;
      cyc(4);
      sda_m = 1'b1;
      cyc(8);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic k0, k1, k2;
      start(1'b0, k0);
      xfer(a, 1'b1, r, k1);
      xfer(d, 1'b1, r, k2);
      stop();
      ok = !(k0 | k1 | k2);
   endtask

   task automatic point(input logic [7:0] a);
      logic [7:0] r;
      logic k;
      start(1'b0, k);
      xfer(a, 1'b1, r, k);
      stop();
   endtask

   task automatic rd(output logic [7:0] d0, output logic [7:0] d1);
      logic k;
      start(1'b1, k);
      xfer(8'hFF, 1'b0, d0, k);
      xfer(8'hFF, 1'b1, d1, k);
      stop();
   endtask
endmodule // gpx_i2c_master

// >>> sim/tb_gpio_expander_pull_irq_core.sv
// Self-checking bench of the expander core reached over its serial bus.
`timescale 1ns/10ps
`include "gpx_map.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end

module tb_gpio_expander_pull_irq_core import gpx_pkg::*;;
   localparam logic [2:0] MID = 3'h5; // Arbitrary value.
   localparam logic [2:0] FWR = 3'h3; // Arbitrary value.
   logic clk = 1'b0, nrst = 1'b0, rst_pin_n = 1'b1, por_ok = 1'b0;
   logic [7:0] pins = 8'h00, hsd, lsd, pu, pd, ibe, d0, d1;
   logic scl, sda_m, sda_o, sda_oe_n, irq_o, irq_oe_n, ok;
   wire logic sda = sda_m & (sda_oe_n | sda_o);
   int n_fail = 0, checks = 0, cycles = 0;

   gpx_core #(.MAKER_ID(MID), .FW_REV(FWR)) dut (.clk(clk), .nrst(nrst), .rst_pin_n(rst_pin_n),
      .por_ok(por_ok), .addr_pin(1'b0), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n), .port_pins(pins), .high_side_driver(hsd), .low_side_driver(lsd),
      .pullup_switch(pu), .pulldown_switch(pd), .input_buf_en(ibe), .irq_o(irq_o),
      .irq_oe_n(irq_oe_n));
   gpx_i2c_master m (.clk(clk), .scl(scl), .sda_m(sda_m), .sda(sda));

   initial begin
      forever #25 clk = ~clk;
   end

   task automatic conclude();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_fail++;
         conclude();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // A second byte of the same read shows what the first read cleared.
   task automatic rdreg(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] e1;
      e1 = (a == `GPX_OFF_PEND) ? 8'h00 : (a == `GPX_OFF_CTRL) ? {e[7:2], 2'b00} : e;
      m.point(a);
      m.rd(d0, d1);
      `CHK(d0, e)
      `CHK(d1, e1)
   endtask

   task automatic wrreg(input logic [7:0] a, input logic [7:0] d);
      m.wr(a, d, ok);
      `CHK(ok, 1'b1)
   endtask

   initial begin
      cyc(6);
      nrst = 1'b1;
      cyc(8);
      `CHK({pu, pd, irq_oe_n}, 17'h01FF)
      por_ok = 1'b1;
      cyc(6);
      `CHK(ibe, 8'hFF)
      rdreg(`GPX_OFF_CTRL, {MID, FWR, 2'b10});
      rdreg(`GPX_OFF_PULL_EN, 8'hFF);
      rdreg(`GPX_OFF_PULL_SEL, 8'h00);
      rdreg(`GPX_OFF_MASK, 8'h00);
      rdreg(8'h02, 8'h00);
      wrreg(`GPX_OFF_PULL_SEL, 8'hF0);
      `CHK({pu, pd}, 16'hF00F)
      wrreg(`GPX_OFF_PULL_EN, 8'h3C);
      `CHK({pu, pd}, 16'h300C)
      wrreg(`GPX_OFF_DIR, 8'h0F);
      wrreg(`GPX_OFF_OUT, 8'h05);
      wrreg(`GPX_OFF_HIZ, 8'h00);
      `CHK({hsd, lsd, ibe}, 24'h050AF0)
      pins = 8'hA5;
      cyc(5);
      `CHK(irq_oe_n, 1'b0)
      wrreg(`GPX_OFF_LEVEL, 8'hFF);
      `CHK(irq_oe_n, 1'b0)
      rdreg(`GPX_OFF_LEVEL, 8'hA0);
      rdreg(`GPX_OFF_PEND, 8'hA0);
      `CHK(irq_oe_n, 1'b1)
      rdreg(`GPX_OFF_PEND, 8'h00);
      pins = 8'h05;
      cyc(6);
      wrreg(`GPX_OFF_MASK, 8'hF0);
      pins = 8'h15;
      cyc(6);
      `CHK(irq_oe_n, 1'b1)
      rdreg(`GPX_OFF_PEND, 8'h10);
      wrreg(`GPX_OFF_MASK, 8'h00);
      wrreg(`GPX_OFF_DFLT, 8'h10);
      pins = 8'h05;
      cyc(6);
      `CHK(irq_oe_n, 1'b0)
      rdreg(`GPX_OFF_PEND, 8'h10);
      wrreg(`GPX_OFF_PULL_SEL, 8'h5A);
      rst_pin_n = 1'b0;
      cyc(10);
      `CHK({pu, pd, hsd, lsd}, 32'h00FF0000)
      m.wr(`GPX_OFF_PULL_SEL, 8'hFF, ok);
      `CHK(ok, 1'b0)
      rst_pin_n = 1'b1;
      cyc(6);
      rdreg(`GPX_OFF_PULL_SEL, 8'h00);
      rdreg(`GPX_OFF_CTRL, {MID, FWR, 2'b10});
      wrreg(`GPX_OFF_MASK, 8'h3C);
      wrreg(`GPX_OFF_CTRL, 8'h01);
      m.rd(d0, d1);
      `CHK({d0, d1}, {MID, FWR, 2'b10, MID, FWR, 2'b00})
      rdreg(`GPX_OFF_MASK, 8'h00);
      conclude();
   end
endmodule // tb_gpio_expander_pull_irq_core
